//--- src/rxotn_pkg.sv
// Constants, carrier types and helper functions of the receive transport-network lane output.
package rxotn_pkg;
    localparam int LANES = 5;
    localparam int WORD_W = 66;
    localparam int BIP_W = 8;
    localparam int PCS_LANES = 20;
    localparam int PCSN_W = 5;
    localparam int SLOT_W = 3;
    localparam int CNT_W = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int SH_HI = 65;
    localparam int SH_LO = 64;
    localparam int SH_W = 2;
    localparam logic [SH_W-1:0] SH_DATA = 2'h1;
    localparam logic [SH_W-1:0] SH_CTRL = 2'h2;
    localparam int BIP_SH_BASE = 3;
    localparam logic [CNT_W-1:0] ENA_ON = 6'h21;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [FIFO_AW:0] FIFO_FULL = 4'h8;
    localparam logic [FIFO_AW:0] PTR_ONE = 4'h1;

    typedef logic [WORD_W-1:0] rxotn_word_t;
    typedef rxotn_word_t [LANES-1:0] rxotn_lanes_t;
    typedef logic [LANES-1:0][BIP_W-1:0] rxotn_bips_t;

    // One cycle of the lane aligner output, taken after the optional FEC stage.
    typedef struct packed {
        logic valid;
        logic marker;
        logic [LANES-1:0][PCSN_W-1:0] num;
        rxotn_lanes_t data;
    } rxotn_in_t;

    // One cycle of reordered output lanes.
    typedef struct packed {
        logic lane0;
        logic marker;
        rxotn_bips_t bip;
        rxotn_lanes_t data;
    } rxotn_rec_t;

    // Whole state of the lane output block.
    typedef struct packed {
        logic lk_s1;
        logic lk_s2;
        logic lk_s3;
        logic rec_v;
        rxotn_rec_t rec;
        logic [LANES-1:0][PCSN_W-1:0] num;
        logic [PCS_LANES-1:0][BIP_W-1:0] acc;
        rxotn_rec_t [FIFO_DEPTH-1:0] mem;
        logic [FIFO_AW:0] wr;
        logic [FIFO_AW:0] rd;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] hi_run;
        logic ena;
        rxotn_rec_t out;
        logic err;
    } rxotn_state_t;

    // Output slot of a PCS lane number.
    function automatic logic [SLOT_W-1:0] lane_slot(input logic [PCSN_W-1:0] num);
        lane_slot = SLOT_W'(num % PCSN_W'(LANES));
    endfunction

    // Parity contribution of one block; bit 7 is the first parity bit on the line.
    function automatic logic [BIP_W-1:0] bip_fold(input rxotn_word_t w);
        logic [BIP_W-1:0] f;
        int j;
        f = '0;
        for (int t = 0; t < WORD_W; t++) begin
            if (t < SH_W) begin
                j = BIP_SH_BASE + t;
            end else begin
                j = (t - SH_W) % BIP_W;
            end
            f[BIP_W-1-j] = f[BIP_W-1-j] ^ w[WORD_W-1-t];
        end
        bip_fold = f;
    endfunction
endpackage

//--- src/rxotn_lane_out.sv
// Receive transport-network lane output with reorder, parity recalculation and clock bridge.
`timescale 1ns/10ps
`default_nettype none

// Function
// RL1: Present five lanes of 66b blocks from the lane aligner output.
// RL2: Alignment marker words stay in the stream and are forwarded.
// RL3: Reorder so logical lane n appears on output lane n.
// RL4: Recalculate per-lane parity over received blocks and output it.
// RL5: Bridge through a FIFO for a foreign clock, else a register pipeline.
// RL6: Exactly five lanes, fixed, locked to the receive core clock.
// RL7: Lane data is taken after the optional FEC stage.
// RL8: Enable high for 33 output cycles then low for one, forever.
// RL9: Output is always active with no enable or select input.
// RL10: Statistics reuse the standard receive statistics; no extra port.
// RL11: Lane data is meaningful only while the enable is one.
// RL12: Lane-zero indicator marks output lane 0 carrying logical lane 0.
// RL13: Marker flag with recalculated parity on all five outputs during markers.
// RL14: Blocks carry header 01 for data and 10 for control.
// RL15: Header bypasses the scrambler and passes untouched.
// RL16: Bit 65 holds the first transmitted header bit.
// RL17: Output lane 0 holds the earliest block, then lanes 1 to 4.
// RL18: Parity bit 7 is the first received bit of the parity field.
// RL19: Words are 66 bits, header in 65:64, payload in 63:0.
// RL20: The output clock should be tied to the core clock.
// RL21: Reset holds enable, indicator and flag low and clears the buffer.
module rxotn_lane_out (
    input wire logic i_clk,                          // Receive core clock.
    input wire logic i_rst,                          // Receive reset, synchronous.
    input wire logic i_same_clk,                     // High when output clock is the core clock.
    input wire logic i_out_clk,                      // Output clock from the framing logic.
    input wire rxotn_pkg::rxotn_in_t i_in,           // Aligned lane words after FEC.
    output logic o_ena,                              // Output enable pattern.
    output logic o_lane_zero_present,                // Output lane 0 holds PCS lane 0.
    output logic o_marker,                           // Alignment marker words on lanes.
    output rxotn_pkg::rxotn_lanes_t o_data,          // Five output lanes.
    output rxotn_pkg::rxotn_bips_t o_lane_parity_out, // Recalculated parity per lane.
    output logic o_xfer_err                          // Bridge overflow or underflow seen.
);
    rxotn_pkg::rxotn_state_t s_q;
    rxotn_pkg::rxotn_state_t s_d;
    logic tick;
    logic push;
    logic pop;
    logic ena_new;
    logic [rxotn_pkg::FIFO_AW:0] fill;
    logic [rxotn_pkg::SLOT_W-1:0] slot;
    logic [rxotn_pkg::BIP_W-1:0] fold;

    // Next-state logic; statistics come from the standard receive path (see RL10).
    always_comb begin
        s_d = s_q;
        slot = '0;
        fold = '0;
        // The first stage only feeds the second, so no logic sees a metastable level.
        s_d.lk_s1 = i_out_clk;
        s_d.lk_s2 = s_q.lk_s1;
        s_d.lk_s3 = s_q.lk_s2;
        // Every core cycle is an output cycle when the clocks are tied (see RL6).
        tick = i_same_clk | (s_q.lk_s2 & ~s_q.lk_s3);
        ena_new = (s_q.cnt != rxotn_pkg::ENA_ON);

        // Reorder stage; data comes from after the FEC stage (see RL7).
        s_d.rec_v = i_in.valid;
        if (i_in.valid) begin
            s_d.rec.marker = i_in.marker; // Markers are forwarded, not dropped (see RL2).
            s_d.rec.bip = '0;
            for (int p = 0; p < rxotn_pkg::LANES; p++) begin
                slot = rxotn_pkg::lane_slot(i_in.num[p]);
                // Whole words move, header bits untouched (see RL15, RL16, RL19, RL14).
                s_d.rec.data[slot] = i_in.data[p]; // see RL3, RL17, RL1
                s_d.num[slot] = i_in.num[p];
                fold = rxotn_pkg::bip_fold(i_in.data[p]); // see RL18
                if (i_in.marker) begin
                    // Marker closes the window of the previous one (see RL4, RL13).
                    s_d.rec.bip[slot] = s_q.acc[i_in.num[p]];
                    s_d.acc[i_in.num[p]] = fold;
                end else begin
                    s_d.acc[i_in.num[p]] = s_q.acc[i_in.num[p]] ^ fold; // see RL4
                end
            end
            s_d.rec.lane0 = (s_d.num[0] == '0); // see RL12
        end

        // Crossing buffer for a foreign output clock (see RL5).
        fill = s_q.wr - s_q.rd;
        push = s_q.rec_v & ~i_same_clk;
        pop = ~i_same_clk & tick & ena_new & (fill != '0);
        if (push) begin
            if ((fill == rxotn_pkg::FIFO_FULL) && !pop) begin
                s_d.err = 1'b1;
            end else begin
                s_d.mem[s_q.wr[rxotn_pkg::FIFO_AW-1:0]] = s_q.rec;
                s_d.wr = s_q.wr + rxotn_pkg::PTR_ONE;
            end
        end

        // Output cycle: enable pattern runs free, no input gates it (see RL8, RL9).
        if (tick) begin
            s_d.ena = ena_new;
            s_d.cnt = ena_new ? (s_q.cnt + rxotn_pkg::CNT_ONE) : '0; // see RL8
            s_d.hi_run = ena_new ? (s_q.hi_run + rxotn_pkg::CNT_ONE) : '0;
            if (i_same_clk) begin
                // Register pipeline; a gap in the source shows as cleared flags (see RL5).
                s_d.out = s_q.rec;
                s_d.out.lane0 = s_q.rec.lane0 & s_q.rec_v;
                s_d.out.marker = s_q.rec.marker & s_q.rec_v;
            end else if (pop) begin
                s_d.out = s_q.mem[s_q.rd[rxotn_pkg::FIFO_AW-1:0]];
                s_d.rd = s_q.rd + rxotn_pkg::PTR_ONE;
            end else begin
                s_d.out.lane0 = 1'b0;
                s_d.out.marker = 1'b0;
                s_d.err = s_q.err | ena_new;
            end
            // Flags never stand in a disabled cycle (see RL11).
            if (!ena_new) begin
                s_d.out.lane0 = 1'b0;
                s_d.out.marker = 1'b0;
            end
            // Parity stands only beside the marker flag; a held or dropped marker takes it along.
            // Without this, an underflow or a gap would show stale parity in an enabled cycle.
            if (!s_d.out.marker) begin
                s_d.out.bip = '0; // see RL13
            end
        end
    end

    // State register; reset clears flags and buffer pointers (see RL21).
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign o_ena = s_q.ena;
    assign o_lane_zero_present = s_q.out.lane0;
    assign o_marker = s_q.out.marker;
    assign o_data = s_q.out.data;
    assign o_lane_parity_out = s_q.out.bip;
    assign o_xfer_err = s_q.err;

    // The enable pattern never runs longer than 33 output cycles high.
    a_ena_run_max: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        s_q.hi_run <= rxotn_pkg::ENA_ON)
        else $error("enable stayed high too long");

    // The enable only falls after exactly 33 high output cycles.
    a_ena_fall_len: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        $fell(o_ena) |-> ($past(s_q.hi_run) == rxotn_pkg::ENA_ON))
        else $error("enable fell after wrong count");

    // With tied clocks the low phase lasts a single cycle.
    a_ena_low_one: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        (i_same_clk && $fell(o_ena)) |=> o_ena)
        else $error("enable low longer than one cycle");

    // The lane-zero indicator never stands outside an enabled cycle.
    a_lane0_gated: assert property (@(posedge i_clk) disable iff (i_rst) // see RL11
        o_lane_zero_present |-> o_ena)
        else $error("lane zero flag without enable");

    // The marker flag never stands outside an enabled cycle.
    a_marker_gated: assert property (@(posedge i_clk) disable iff (i_rst) // see RL13
        o_marker |-> o_ena)
        else $error("marker flag without enable");

    // Parity outputs carry values only with the marker flag.
    a_bip_marker_only: assert property (@(posedge i_clk) disable iff (i_rst) // see RL4
        (o_ena && !o_marker) |-> (o_lane_parity_out == '0))
        else $error("parity shown outside marker");

    // Reorder slot 0 holds the lane whose number belongs there, and the lane-zero flag agrees.
    a_reorder_slot: assert property (@(posedge i_clk) disable iff (i_rst) // see RL3
        s_q.rec_v |-> ((rxotn_pkg::lane_slot(s_q.num[0]) == '0)
            && (s_q.rec.lane0 == (s_q.num[0] == '0))))
        else $error("lane zero slot misplaced");

    // The crossing buffer never holds more than its depth.
    a_fifo_bound: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        (s_q.wr - s_q.rd) <= rxotn_pkg::FIFO_FULL)
        else $error("buffer fill beyond depth");

    // With tied clocks the output follows the reorder stage by one cycle.
    a_pipe_follow: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        (i_same_clk && $past(i_same_clk)) |-> (o_data == $past(s_q.rec.data)))
        else $error("pipeline output mismatch");

    // Right after reset the flags are low.
    a_reset_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // see RL21
        $past(i_rst) |-> (!o_ena && !o_lane_zero_present && !o_marker))
        else $error("flags high after reset");

    // The error flag is sticky; only reset clears it.
    a_err_sticky: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        $past(o_xfer_err) |-> o_xfer_err)
        else $error("error flag cleared without reset");

    // The register pipeline has no buffer, so it can never report a crossing error.
    a_pipe_no_err: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        i_same_clk |-> !o_xfer_err)
        else $error("crossing error in pipeline mode");

    // The crossing buffer stays idle while the clocks are tied.
    a_pipe_fifo_idle: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        i_same_clk |-> (s_q.wr == s_q.rd))
        else $error("buffer used in pipeline mode");

    // The phase counter never passes the length of the high run.
    a_cnt_bound: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        s_q.cnt <= rxotn_pkg::ENA_ON)
        else $error("enable counter out of range");

    // The enable is high exactly while the phase counter is running.
    a_ena_cnt_match: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        o_ena == (s_q.cnt != '0))
        else $error("enable and counter disagree");

    // With tied clocks the enable drops right after the 33rd high cycle.
    a_ena_low_after: assert property (@(posedge i_clk) disable iff (i_rst) // see RL8
        (i_same_clk && (s_q.cnt == rxotn_pkg::ENA_ON)) |=> !o_ena)
        else $error("enable missed its low cycle");

    // Lane outputs and the enable stand still between output ticks, as the framing side samples them there.
    a_hold_no_tick: assert property (@(posedge i_clk) disable iff (i_rst) // see RL11
        !$past(tick) |-> ($stable(o_data) && $stable(o_ena)))
        else $error("output moved without a tick");

    // In bridge mode new words appear only in enabled cycles.
    a_bridge_pop_ena: assert property (@(posedge i_clk) disable iff (i_rst) // see RL11
        (!i_same_clk && $changed(o_data)) |-> o_ena)
        else $error("bridge data changed while disabled");

    // Parity outputs are quiet in every disabled cycle.
    a_parity_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // see RL13
        !o_ena |-> (o_lane_parity_out == '0))
        else $error("parity shown while disabled");

    // The third sampling stage only ever copies the second one.
    a_sync_chain: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        s_q.lk_s3 == $past(s_q.lk_s2))
        else $error("clock sampler out of step");

    // A push into a full buffer with no pop raises the error flag.
    a_overflow_flag: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        (push && (fill == rxotn_pkg::FIFO_FULL) && !pop) |=> o_xfer_err)
        else $error("overflow not flagged");

    // An enabled bridge tick with an empty buffer raises the error flag.
    a_underflow_flag: assert property (@(posedge i_clk) disable iff (i_rst) // see RL5
        (!i_same_clk && tick && ena_new && (fill == '0)) |=> o_xfer_err)
        else $error("underflow not flagged");

    // The reorder stage takes every offered cycle of the aligner.
    a_rec_follow: assert property (@(posedge i_clk) disable iff (i_rst) // see RL1
        s_q.rec_v == $past(i_in.valid))
        else $error("reorder stage missed a word");
endmodule

`default_nettype wire

//--- tb/rxotn_partner.sv
// Framing-side model: makes the output clock and keeps the enabled lane words.
`timescale 1ns/10ps
`default_nettype none
module rxotn_partner (
    input wire logic i_run,                       // Let the output clock toggle.
    input wire rxotn_pkg::rxotn_lanes_t i_data,   // Lane words from the lane output.
    input wire logic i_ena,                       // Enable from the lane output.
    output logic o_out_clk                        // Output clock, 160 ns period.
);
    rxotn_pkg::rxotn_lanes_t got[$];

    // The clock stands still while stopped, so a held buffer is never drained.
    initial begin
        o_out_clk = 1'b0;
        #7;
        forever begin
            #80;
            if (i_run) begin
                o_out_clk = ~o_out_clk;
            end
        end
    end

    // Words are kept only in enabled cycles; all other cycles are ignored.
    always @(posedge o_out_clk) begin
        if (i_ena === 1'b1) begin
            got.push_back(i_data);
        end
    end
endmodule
`default_nettype wire

//--- tb/rxotn_lane_out_tb.sv
// Self-checking bench of the lane output in pipeline and bridge modes.
`timescale 1ns/10ps
`default_nettype none
module rxotn_lane_out_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_same_clk = 1'b1;
    logic run = 1'b0;
    logic out_clk;
    logic o_ena, o_lane_zero_present, o_marker, o_xfer_err;
    rxotn_pkg::rxotn_in_t i_in = '0;
    rxotn_pkg::rxotn_lanes_t o_data;
    rxotn_pkg::rxotn_bips_t o_lane_parity_out;
    rxotn_pkg::rxotn_rec_t q[$];
    rxotn_pkg::rxotn_lanes_t sent[$];
    logic [7:0] acc [20];
    logic [31:0] seed = 32'h4d3aaf8c;
    int num_errors = 0;
    int comparisons = 0;

    // Core clock at 50 MHz.
    always #10 i_clk = ~i_clk;

    rxotn_lane_out i_rxotn_lane_out (.i_clk(i_clk), .i_rst(i_rst), .i_same_clk(i_same_clk),
        .i_out_clk(out_clk), .i_in(i_in), .o_ena(o_ena), .o_marker(o_marker),
        .o_lane_zero_present(o_lane_zero_present), .o_data(o_data),
        .o_lane_parity_out(o_lane_parity_out), .o_xfer_err(o_xfer_err));
    rxotn_partner i_rxotn_partner (.i_run(run), .i_data(o_data), .i_ena(o_ena),
        .o_out_clk(out_clk));

    // Repeatable random source.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Parity of one block in line order; the two header bits land on parity bits 3 and 4.
    function automatic logic [7:0] fold(input logic [65:0] w);
        logic [7:0] f;
        f = '0;
        for (int t = 0; t < 66; t++) begin
            f[7 - (t < 2 ? 3 + t : (t - 2) % 8)] ^= w[65 - t];
        end
        return f;
    endfunction

    // Comparisons of flags and of wide values.
    task automatic cmp_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (e !== g) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic cmp_vec(input string n, input logic [329:0] e, input logic [329:0] g);
        comparisons++;
        if (e !== g) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // One cycle of shuffled lanes; the expectation is kept in logical order.
    task automatic drive(input int c, input logic mk);
        rxotn_pkg::rxotn_in_t d;
        rxotn_pkg::rxotn_rec_t e;
        logic [65:0] w;
        int r, n;
        d = '0;
        e = '0;
        d.valid = 1'b1;
        d.marker = mk;
        r = int'(rnd() % 5);
        for (int k = 0; k < 5; k++) begin
            w = {2'h0, rnd(), rnd()};
            w[65:64] = w[0] ? rxotn_pkg::SH_DATA : rxotn_pkg::SH_CTRL;
            n = 5 * (c % 4) + k;
            d.data[(k + r) % 5] = w;
            d.num[(k + r) % 5] = 5'(n);
            e.data[k] = w;
            e.bip[k] = mk ? acc[n] : 8'h00;
            acc[n] = mk ? fold(w) : acc[n] ^ fold(w);
        end
        e.marker = mk;
        e.lane0 = (c % 4 == 0);
        i_in <= d;
        q.push_back(e);
        sent.push_back(e.data);
    endtask

    // Reset for eight cycles; every flag must be low by then.
    task automatic do_reset(input logic same);
        i_rst <= 1'b1;
        i_same_clk <= same;
        i_in <= '0;
        repeat (8) @(posedge i_clk);
        #1;
        cmp_bit("flags_in_reset", 1'b0, o_ena | o_marker | o_lane_zero_present | o_xfer_err);
        i_rst <= 1'b0;
        q.delete();
        sent.delete();
        foreach (acc[i]) acc[i] = 8'h00;
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: pipeline mode with markers, then bridge mode and an overflow.
    initial begin
        rxotn_pkg::rxotn_rec_t e;
        int hi, lo;
        hi = 0;
        lo = -1;
        do_reset(1'b1);
        for (int c = 0; c < 300; c++) begin
            @(posedge i_clk);
            drive(c, c % 32 < 4);
            #1;
            if (q.size() > 2) begin
                e = q.pop_front();
                cmp_vec("data", e.data, o_data);
                cmp_bit("marker", e.marker & o_ena, o_marker);
                cmp_bit("lane_zero", e.lane0 & o_ena, o_lane_zero_present);
                cmp_vec("parity", 330'((e.marker && o_ena === 1'b1) ? e.bip : '0),
                    330'(o_lane_parity_out));
            end
            // The low run is only measured once the first high run has been seen.
            if (o_ena === 1'b1) begin
                if (lo > 0) cmp_vec("ena_low_run", 330'(1), 330'(lo));
                lo = 0;
                hi++;
            end else begin
                if (hi > 0) cmp_vec("ena_high_run", 330'(33), 330'(hi));
                hi = 0;
                if (lo >= 0) lo++;
            end
        end
        cmp_bit("pipe_err", 1'b0, o_xfer_err);
        do_reset(1'b0);
        // Prefill four words with the clock stopped, then one word per output tick.
        for (int c = 0; c < 24; c++) begin
            @(posedge i_clk);
            drive(c, 1'b0);
            @(posedge i_clk);
            i_in.valid <= 1'b0;
            run <= (c >= 3);
            if (c >= 3) repeat (6) @(posedge i_clk);
        end
        run <= 1'b0;
        repeat (16) @(posedge i_clk);
        for (int i = 0; i < i_rxotn_partner.got.size(); i++) begin
            cmp_vec("bridge_word", sent[i], i_rxotn_partner.got[i]);
        end
        cmp_bit("bridge_count", 1'b1, i_rxotn_partner.got.size() > 12);
        cmp_bit("bridge_err", 1'b0, o_xfer_err);
        // With the clock stopped, ten more words overrun the eight-entry buffer.
        repeat (10) begin
            @(posedge i_clk);
            drive(0, 1'b0);
        end
        @(posedge i_clk);
        i_in.valid <= 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        cmp_bit("overflow_err", 1'b1, o_xfer_err);
        // A running output clock with an empty buffer must report an underflow.
        do_reset(1'b0);
        run <= 1'b1;
        repeat (48) @(posedge i_clk);
        #1;
        cmp_bit("underflow_err", 1'b1, o_xfer_err);
        run <= 1'b0;
        do_reset(1'b1);
        close_out();
    end

    // Watchdog well beyond the expected run of about 12 us.
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
